// ---- logic/display_loader_pkg.sv ----
// constants and types for the cascaded display loader
package display_loader_pkg;
    localparam int CLK_NS = 5;
    localparam int SCLK_HALF_NS = 100;
    localparam int LEAD_NS = 100;
    localparam int ENH_NS = 500;
    localparam logic [7:0] HALF_C = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS - 1);
    localparam logic [7:0] LEAD_C = 8'((LEAD_NS + CLK_NS - 1) / CLK_NS - 1);
    localparam logic [7:0] ENH_C = 8'((ENH_NS + CLK_NS - 1) / CLK_NS - 1);
    localparam int MAXB = 20;
    localparam logic [2:0] MINDEV = 3'h2;
    localparam logic [2:0] MAXDEV = 3'h6;
    localparam logic [4:0] SPLIT_FIRST = 5'h06;
    localparam logic [7:0] CTRL_A = 8'h00;
    localparam logic [7:0] STAT_A = 8'h04;
    localparam logic [7:0] BUF_A = 8'h40;
    localparam int START_B = 0;
    localparam int DISP_B = 1;
    localparam int SPLIT_B = 2;
    localparam int NDEV_L = 4;
    localparam int IDX_L = 8;
    localparam int PH_L = 16;
    typedef enum logic [2:0] {
        IDLE = 3'h0,
        LEAD = 3'h1,
        SHIFT = 3'h2,
        PULSE = 3'h3,
        HOLD = 3'h4
    } phase_type;
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic enableN;
    } pins_type;
    typedef struct packed {
        phase_type ph;
        logic [7:0] cnt;
        logic [4:0] idx;
        logic [4:0] last;
        logic [4:0] pad;
        logic [2:0] bitc;
        logic [7:0] sh;
        logic sclk;
        logic mosi;
        logic enN;
        logic busy;
        logic disp;
        logic split;
        logic [2:0] ndev;
        logic ack;
        logic [31:0] rdat;
        logic [MAXB-1:0][7:0] mem;
    } state_type;
endpackage

// ---- logic/display_loader.sv ----
// host controller that loads a chain of cascaded display drivers
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module display_loader
    import display_loader_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    output pins_type pins
);
    state_type s_q;
    state_type s_d;
    logic req;
    logic [4:0] bufIdx;
    logic bufHit;
    logic [2:0] nReq;

    // pad bytes from device count
    function automatic logic [4:0] padOf(input logic [2:0] n);
        logic [4:0] t;
        t = 5'(n) * 5'h03;
        if (t[1:0] == 2'h0) begin
            padOf = 5'h02;
        end else if (t[1:0] == 2'h1) begin
            padOf = 5'h01;
        end else begin
            padOf = 5'h00;
        end
    endfunction

    // total stream length
    function automatic logic [4:0] totalOf(input logic [2:0] n, input logic disp);
        logic [4:0] t;
        t = 5'(n) * 5'h03;
        if (t[1:0] == 2'h0) begin
            totalOf = t;
        end else if (t[1:0] == 2'h1) begin
            totalOf = t - 5'h01;
        end else begin
            totalOf = t - 5'h02;
        end
        if (disp) begin
            totalOf = totalOf + 5'h02;
        end
    endfunction

    // byte to send, pad bytes are zero
    function automatic logic [7:0] fetch(input state_type s, input logic [4:0] i);
        fetch = (i < s.pad) ? 8'h00 : s.mem[i];
    endfunction

    assign req = wbCyc && wbStb && !s_q.ack;
    assign bufIdx = 5'((wbAdr - BUF_A) >> 2);
    assign bufHit = (wbAdr >= BUF_A) && (bufIdx < 5'(MAXB)) && (wbAdr[1:0] == 2'h0);
    assign nReq = wbDatW[NDEV_L+:3] < MINDEV ? MINDEV :
                  (wbDatW[NDEV_L+:3] > MAXDEV ? MAXDEV : wbDatW[NDEV_L+:3]);

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        if (req) begin
            s_d.rdat = 32'h0;
            if (wbAdr == CTRL_A) begin
                s_d.rdat[DISP_B] = s_q.disp;
                s_d.rdat[SPLIT_B] = s_q.split;
                s_d.rdat[NDEV_L+:3] = s_q.ndev;
            end else if (wbAdr == STAT_A) begin
                s_d.rdat[0] = s_q.busy;
                s_d.rdat[IDX_L+:5] = s_q.idx;
                s_d.rdat[PH_L+:3] = s_q.ph;
            end else if (bufHit) begin
                s_d.rdat[7:0] = s_q.mem[bufIdx];
            end
        end
        if (req && wbWe && wbSel[0] && !s_q.busy) begin
            if (bufHit) begin
                s_d.mem[bufIdx] = wbDatW[7:0];
            end else if (wbAdr == CTRL_A) begin
                s_d.disp = wbDatW[DISP_B];
                s_d.split = wbDatW[SPLIT_B];
                s_d.ndev = nReq;
                if (wbDatW[START_B]) begin
                    s_d.pad = padOf(nReq);
                    s_d.last = totalOf(nReq, wbDatW[DISP_B]);
                    s_d.idx = (wbDatW[SPLIT_B] && wbDatW[DISP_B]) ? padOf(nReq) : 5'h00;
                    s_d.busy = 1'b1;
                    s_d.enN = 1'b0;
                    s_d.ph = LEAD;
                    s_d.cnt = LEAD_C;
                end
            end
        end
        case (s_q.ph)
            IDLE: begin
                s_d.sclk = 1'b0;
            end
            LEAD: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.ph = SHIFT;
                    s_d.sh = fetch(s_q, s_q.idx);
                    s_d.mosi = s_d.sh[7];
                    s_d.bitc = 3'h7;
                    s_d.cnt = HALF_C;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            SHIFT: begin
                if (s_q.cnt != 8'h00) begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end else if (!s_q.sclk) begin
                    s_d.sclk = 1'b1;
                    s_d.cnt = HALF_C;
                end else begin
                    s_d.sclk = 1'b0;
                    s_d.cnt = HALF_C;
                    if (s_q.bitc != 3'h0) begin
                        s_d.bitc = s_q.bitc - 3'h1;
                        s_d.sh = {s_q.sh[6:0], 1'b0};
                        s_d.mosi = s_q.sh[6];
                    end else begin
                        s_d.idx = s_q.idx + 5'h01;
                        if (s_d.idx == s_q.last) begin
                            s_d.ph = HOLD;
                            s_d.enN = 1'b1;
                            s_d.cnt = ENH_C;
                        end else if (s_q.split && s_q.disp && s_q.pad != 5'h00 &&
                                     s_d.idx == s_q.pad + SPLIT_FIRST) begin
                            s_d.ph = PULSE;
                            s_d.enN = 1'b1;
                            s_d.cnt = ENH_C;
                        end else begin
                            s_d.sh = fetch(s_q, s_d.idx);
                            s_d.mosi = s_d.sh[7];
                            s_d.bitc = 3'h7;
                        end
                    end
                end
            end
            PULSE: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.enN = 1'b0;
                    s_d.ph = LEAD;
                    s_d.cnt = LEAD_C;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            HOLD: begin
                if (s_q.cnt == 8'h00) begin
                    s_d.ph = IDLE;
                    s_d.busy = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            default: begin
                s_d.ph = IDLE;
                s_d.enN = 1'b1;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.enN <= 1'b1;
            s_q.ndev <= MINDEV;
        end else begin
            s_q <= s_d;
        end
    end

    assign wbAck = s_q.ack;
    assign wbDatR = s_q.rdat;
    assign pins = '{
        sclk: s_q.sclk,
        mosi: s_q.mosi,
        enableN: s_q.enN
    };

    idle_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == IDLE |-> s_q.enN && !s_q.sclk)
        else $error("enable not high while idle");
    clk_in_frame_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.sclk |-> !s_q.enN)
        else $error("serial clock outside enable low");
    whole_stream_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.enN) && s_q.ph == HOLD |-> s_q.idx == s_q.last)
        else $error("enable raised before last byte");
    pad_two_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && ((5'(s_q.ndev) * 5'h03) & 5'h03) == 5'h00 |-> s_q.pad == 5'h02)
        else $error("wrong pad for 3N multiple of four");
    pad_one_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && ((5'(s_q.ndev) * 5'h03) & 5'h03) == 5'h01 |-> s_q.pad == 5'h01)
        else $error("wrong pad for 3N-1 multiple of four");
    pad_none_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && ((5'(s_q.ndev) * 5'h03) & 5'h02) != 5'h00 |-> s_q.pad == 5'h00)
        else $error("pad present where none belongs");
    split_after_six_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.enN) && s_q.ph == PULSE |-> s_q.idx == s_q.pad + SPLIT_FIRST)
        else $error("split pulse not after six bytes");
    pulse_width_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.enN) && s_q.ph == PULSE |-> s_q.enN [*8])
        else $error("split pulse too short");
    chain_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy |-> s_q.ndev >= MINDEV && s_q.ndev <= MAXDEV)
        else $error("device count out of range");
    lead_setup_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s_q.enN) |-> !s_q.sclk ##1 !s_q.sclk)
        else $error("clock edge too close to enable fall");
    pad_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == SHIFT && s_q.idx < s_q.pad |-> !s_q.mosi)
        else $error("pad byte not zero");
    start_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.busy) |-> $past(s_q.enN) && !s_q.enN)
        else $error("transfer started without enable high");
    fall_in_lead_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s_q.enN) |-> s_q.ph == LEAD)
        else $error("enable fell outside lead phase");
    idle_not_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == IDLE |-> !s_q.busy)
        else $error("busy while idle");
    low_means_busy_a: assert property (@(posedge ref_clk) disable iff (rst)
        !s_q.enN |-> s_q.busy)
        else $error("enable low while not busy");
    mosi_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.sclk |-> $stable(s_q.mosi))
        else $error("data changed while clock high");
    sclk_high_span_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.sclk) |-> s_q.sclk [*8])
        else $error("serial clock high too short");
    sclk_low_span_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s_q.sclk) && !s_q.enN |-> !s_q.sclk [*8])
        else $error("serial clock low too short");
    two_dev_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && s_q.ndev == 3'h2 |-> s_q.last == (s_q.disp ? 5'h06 : 5'h04))
        else $error("wrong length for two devices");
    hold_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == HOLD |-> s_q.enN && !s_q.sclk)
        else $error("activity during commit hold");
    hold_length_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.enN) && s_q.ph == HOLD |-> s_q.enN [*8])
        else $error("commit high too short");
    three_dev_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && s_q.ndev == 3'h3 |-> s_q.last == (s_q.disp ? 5'h0a : 5'h08))
        else $error("wrong length for three devices");
    shift_only_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == SHIFT |-> !s_q.enN)
        else $error("shifting with enable high");
    split_three_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.enN) && s_q.ph == PULSE && s_q.ndev == 3'h3 |-> s_q.idx == 5'h07 && s_q.last == 5'h0a)
        else $error("three device split misplaced");
    split_display_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == PULSE |-> s_q.disp && s_q.split && s_q.pad != 5'h00)
        else $error("split pulse outside padded display");
    four_dev_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && s_q.ndev == 3'h4 |-> s_q.last == (s_q.disp ? 5'h0e : 5'h0c))
        else $error("wrong length for four devices");
    split_four_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.enN) && s_q.ph == PULSE && s_q.ndev == 3'h4 |-> s_q.idx == 5'h08 && s_q.last == 5'h0e)
        else $error("four device split misplaced");
    pulse_relead_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == PULSE && s_q.cnt == 8'h00 |=> s_q.ph == LEAD && !s_q.enN)
        else $error("enable not low after split pulse");
    split_skip_pad_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.ph == SHIFT && s_q.split && s_q.disp |-> s_q.idx >= s_q.pad)
        else $error("pad byte sent in split stream");
    five_dev_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && s_q.ndev == 3'h5 |-> s_q.last == (s_q.disp ? 5'h0f : 5'h0d))
        else $error("wrong length for five devices");
    six_dev_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && s_q.ndev == 3'h6 |-> s_q.last == (s_q.disp ? 5'h12 : 5'h10))
        else $error("wrong length for six devices");
    split_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.busy) && s_q.split && s_q.disp |-> s_q.idx == s_q.pad)
        else $error("split stream not starting after pad");
    start_index_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_q.busy) && !s_q.split |-> s_q.idx == 5'h00)
        else $error("plain stream not starting at byte zero");
    count_fixed_a: assert property (@(posedge ref_clk) disable iff (rst)
        s_q.busy && $past(s_q.busy) |-> $stable(s_q.ndev))
        else $error("device count changed during transfer");
endmodule
`default_nettype wire

// ---- sim/display_chain_model.sv ----
// behavioural chain of cascaded display drivers
`timescale 1ns/100ps
`default_nettype none
module display_chain_model
    import display_loader_pkg::*;
(
    input wire pins_type pins
);
    logic [7:0] rx [0:255];
    logic [7:0] sh = 8'h00;
    int wp = 0;
    int bits = 0;
    int frames[$];
    logic [23:0] word = 24'h000000;
    logic [23:0] dispReg = 24'h000000;
    logic [7:0] cfgReg = 8'h00;
    wire logic brightnessSelectBit;
    wire logic decimalLampCtlBitA;
    wire logic decimalLampCtlBitB;
    wire logic decimalLampCtlBitC;
    assign brightnessSelectBit = dispReg[23];
    assign decimalLampCtlBitA = dispReg[20];
    assign decimalLampCtlBitB = dispReg[21];
    assign decimalLampCtlBitC = dispReg[22];
    always @(posedge pins.sclk) begin
        if (pins.enableN === 1'b0) begin
            sh = {sh[6:0], pins.mosi};
            word = {word[22:0], pins.mosi};
            bits = bits + 1;
            if (bits % 8 == 0) begin
                rx[wp] = sh;
                wp = wp + 1;
            end
        end
    end
    always @(posedge pins.enableN) begin
        if (bits != 0) begin
            frames.push_back(bits);
            if (bits == 32 || bits == 64 || bits == 96 || bits == 104 || bits == 128) begin
                cfgReg = word[7:0];
            end else begin
                dispReg = word;
            end
        end
        bits = 0;
    end
endmodule
`default_nettype wire

// ---- sim/display_loader_test.sv ----
// bench for the cascaded display loader
`timescale 1ns/100ps
`default_nettype none
module display_loader_test
    import display_loader_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'hf;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    pins_type pins;
    int miscompares = 0;
    int check_count = 0;
    always #2.5 ref_clk = ~ref_clk;
    display_loader dut (.ref_clk(ref_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .pins(pins));
    display_chain_model chain (.pins(pins));
    function automatic logic [7:0] pat(input int j);
        return 8'(8'h35 * j + 8'h1b);
    endfunction
    task automatic finish_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        do begin
            @(posedge ref_clk);
        end while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic xfer(input int nw, input int n, input int d, input int s);
        int pad;
        int tot;
        int base;
        int t;
        int j0;
        logic [31:0] q;
        pad = (3 * n % 4 == 0) ? 2 : (3 * n % 4 == 1) ? 1 : 0;
        tot = 3 * n - 2 + pad + 2 * d;
        base = chain.wp;
        s = (s != 0 && d != 0 && pad > 0) ? 1 : 0;
        j0 = (s != 0) ? pad : 0;
        wb(1'b1, CTRL_A, 32'((nw << 4) | (s << 2) | (d << 1) | 1), q);
        wb(1'b1, BUF_A, 32'h000000ff, q);
        wb(1'b0, STAT_A, 32'h0, q);
        check(q, 32'((1 << PH_L) | (j0 << IDX_L) | 1));
        t = 0;
        do begin
            wb(1'b0, STAT_A, 32'h0, q);
            t++;
        end while (q[0] !== 1'b0 && t < 4000);
        check(32'(t < 4000), 32'h1);
        wb(1'b0, CTRL_A, 32'h0, q);
        check(q, 32'((n << NDEV_L) | (s << SPLIT_B) | (d << DISP_B)));
        if (s != 0) begin
            check(32'(chain.frames.pop_front()), 32'(48));
            check(32'(chain.frames.pop_front()), 32'(8 * (tot - pad - 6)));
        end else begin
            check(32'(chain.frames.pop_front()), 32'(8 * tot));
        end
        if (d != 0) begin
            check(32'(chain.dispReg), 32'({pat(tot - 3), pat(tot - 2), pat(tot - 1)}));
            check(32'(chain.brightnessSelectBit), 32'(pat(tot - 3) >> 7));
            check(32'({chain.decimalLampCtlBitC, chain.decimalLampCtlBitB, chain.decimalLampCtlBitA}),
                32'((pat(tot - 3) >> 4) & 8'h07));
        end else begin
            check(32'(chain.cfgReg), 32'(pat(tot - 1)));
        end
        for (int j = j0; j < tot; j++) begin
            check(chain.rx[base + j - j0], (j < pad) ? 32'h0 : 32'(pat(j)));
        end
        check(32'(pins.enableN), 32'h1);
        check(32'(pins.sclk), 32'h0);
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        miscompares++;
        finish_test();
    end
    initial begin
        logic [31:0] q;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check(32'(pins.enableN), 32'h1);
        check(32'(pins.sclk), 32'h0);
        for (int i = 0; i < MAXB; i++) begin
            wb(1'b1, 8'(BUF_A + 4 * i), 32'(pat(i)), q);
        end
        wb(1'b0, 8'h20, 32'h0, q);
        check(q, 32'h0);
        wb(1'b0, STAT_A, 32'h0, q);
        check(32'(q[0]), 32'h0);
        for (int n = 2; n <= 6; n++) begin
            xfer(n, n, 0, 0);
            xfer(n, n, 1, 0);
        end
        xfer(3, 3, 1, 1);
        xfer(4, 4, 1, 1);
        xfer(7, 6, 0, 0);
        xfer(1, 2, 0, 0);
        finish_test();
    end
endmodule
`default_nettype wire
